// *** flash_front.v ***
// Purpose: Device-side serial interface front end of a serial flash.
// Assumes: The serial clock is far slower than mclk and is sampled by it.
// Notes: The array, status storage and program engine sit outside.
`timescale 1ns/100ps
`include "flash_front_regs.vh"
module flash_front (
   // System clock and reset.
   input wire mclk,
   input wire rst_b,
   // Serial pins from the host.
   input wire spi_clk,
   input wire spi_cs_b,
   input wire [3:0] io_in,
   output reg [3:0] io_out,
   output reg [3:0] io_oe,
   // Status bits held outside.
   input wire four_line_enable_bit,
   input wire status_protect_lo,
   input wire status_protect_hi,
   input wire [15:0] status_in,
   // Array read port.
   input wire [7:0] rd_data,
   output wire [23:0] rd_addr,
   output reg rd_req,
   // Array write and erase port.
   output reg [7:0] wr_byte,
   output reg wr_byte_vld,
   output reg array_go,
   output reg [7:0] array_op,
   output reg [23:0] array_addr,
   output reg sr_wr_go,
   output reg [15:0] sr_wr_data,
   output reg [1:0] sr_wr_count,
   input wire op_done,
   // Mode and state indications.
   output reg write_enable_latch,
   output reg four_line_instruction_mode,
   output reg powered_down,
   output reg paused
);
   // One-hot protocol states.
   localparam [6:0] ST_CMD = 7'h01;
   localparam [6:0] ST_ADDR = 7'h02;
   localparam [6:0] ST_DUMMY = 7'h04;
   localparam [6:0] ST_DOUT = 7'h08;
   localparam [6:0] ST_DIN = 7'h10;
   localparam [6:0] ST_DONE = 7'h20;
   localparam [6:0] ST_IGN = 7'h40;

   // Shift bits in from the lanes in use, most significant first.
   function [7:0] shift_in;
      input [7:0] s;
      input [2:0] w;
      input [3:0] io;
      begin
         case (w)
            `LANES_1: shift_in = {s[6:0], io[0]};
            `LANES_2: shift_in = {s[5:0], io[1:0]};
            default: shift_in = {s[3:0], io};
         endcase
      end
   endfunction

   reg [1:0] rst_pipe_r; // Reset release pipeline.
   wire rst_sync_b; // Released reset used by everything else.
   wire sclk_s; // Synchronised serial clock.
   wire cs_b_s; // Synchronised chip select.
   wire [3:0] io_s; // Synchronised data lines.
   reg sclk_q_r; // Previous serial clock sample.
   reg cs_q_r; // Previous chip select sample.
   reg armed_r; // Select has been seen high since reset.
   reg puw_done_r; // Power-up write delay has expired.
   reg [9:0] puw_cnt_r; // Power-up delay counter.
   reg [6:0] st_r; // Protocol state.
   reg [7:0] op_r; // Current opcode.
   reg [7:0] sh_r; // Receive shifter.
   reg [2:0] bcnt_r; // Bits received in the current byte.
   reg [2:0] w_r; // Receive lane width.
   reg [1:0] nbyte_r; // Address bytes received.
   reg [23:0] addr_r; // Address, advanced during reads.
   reg [2:0] dcnt_r; // Dummy clocks counted.
   reg [7:0] out_r; // Transmit shifter.
   reg [2:0] ocnt_r; // Bits left in the transmit shifter.
   reg [2:0] ow_r; // Transmit lane width.
   reg drive_r; // First output bit has been driven.

   // Reset is asserted at once and released over two clocks.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe_r <= 2'b00;
      end else begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe_r[1];

   // All pins pass two flops; select resets low so only a real high arms it.
   sync_bits #(.W(6), .RST_VAL(6'h2f)) u_sync (
      .clk(mclk),
      .rst_b(rst_sync_b),
      .d({spi_clk, spi_cs_b, io_in}),
      .q({sclk_s, cs_b_s, io_s})
   );

   wire sclk_rise = sclk_s & ~sclk_q_r;
   wire sclk_fall = ~sclk_s & sclk_q_r;
   wire cs_rise = cs_b_s & ~cs_q_r;
   // Selection counts only once select has been high after reset.
   wire sel = ~cs_b_s & armed_r;
   // Pause is only offered outside quad and four-line operation.
   wire hold_en = sel & ~four_line_enable_bit & ~four_line_instruction_mode;
   // A paused device ignores clock and data but keeps its state.
   wire act = sel & ~paused;
   // Edges are only looked at after select fell, so mode 3 is safe.
   wire rx = act & sclk_rise;
   wire tx = act & sclk_fall;
   wire [3:0] bsum = {1'b0, bcnt_r} + {1'b0, w_r};
   wire byte_done = bsum[3];
   wire [7:0] rx_byte = shift_in(sh_r, w_r, io_s);
   // In four-line mode the opcode arrives on four lanes in two clocks.
   wire [2:0] cmd_w = four_line_instruction_mode ? `LANES_4 : `LANES_1;
   // Write instructions need the latch and an expired power-up delay.
   wire wr_ok = write_enable_latch & puw_done_r;
   wire is_read = (op_r == `OP_FRD2) | (op_r == `OP_FRD4);
   wire wp_b = four_line_enable_bit | io_s[2];
   // Status writes blocked by lock bits or by the protect pin.
   wire sr_ok = ~status_protect_hi & ~(status_protect_lo & ~wp_b);
   wire [2:0] dummy_lim = (op_r == `OP_FRD4) ? `DUMMY_QUAD : `DUMMY_DUAL;
   wire [15:0] status_view;
   // Latch and four-line enable are shown at their status positions.
   assign status_view = {status_in[15:`SR_FLE_BIT+1], four_line_enable_bit,
                         status_in[`SR_FLE_BIT-1:`SR_WEN_BIT+1], write_enable_latch,
                         status_in[`SR_WEN_BIT-1:0]};
   wire [7:0] status_byte = (op_r == `OP_RDSR2) ? status_view[15:8] : status_view[7:0];
   assign rd_addr = addr_r;

   // Edge history, select arming and the power-up write delay.
   always @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         sclk_q_r <= 1'b1;
         cs_q_r <= 1'b1;
         armed_r <= 1'b0;
         puw_cnt_r <= 10'h000;
         puw_done_r <= 1'b0;
      end else begin
         sclk_q_r <= sclk_s;
         cs_q_r <= cs_b_s;
         if (cs_b_s) begin
            armed_r <= 1'b1;
         end
         // The delay runs from reset release, standing in for supply rise.
         if (puw_cnt_r == `PUW_CYCLES - 1) begin
            puw_done_r <= 1'b1;
         end else begin
            puw_cnt_r <= puw_cnt_r + 10'h001;
         end
      end
   end

   // Pause follows the pause input only while the serial clock is low.
   always @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         paused <= 1'b0;
      end else if (!hold_en) begin
         paused <= 1'b0;
      end else if (!sclk_s) begin
         paused <= ~io_s[3];
      end
   end

   // Output lanes and enables; floated when paused or deselected.
   always @* begin
      io_out = 4'h0;
      io_oe = 4'h0;
      if (drive_r & act & (st_r == ST_DOUT)) begin
         case (ow_r)
            `LANES_1: begin
               io_out = {2'b00, out_r[7], 1'b0};
               io_oe = 4'h2;
            end
            `LANES_2: begin
               io_out = {2'b00, out_r[7:6]};
               io_oe = 4'h3;
            end
            default: begin
               io_out = out_r[7:4];
               io_oe = 4'hf;
            end
         endcase
      end
   end

   // Protocol engine: receive on rising edges, send on falling edges.
   always @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_r <= ST_CMD;
         op_r <= 8'h00;
         sh_r <= 8'h00;
         bcnt_r <= 3'h0;
         w_r <= `LANES_1;
         nbyte_r <= 2'h0;
         addr_r <= 24'h000000;
         dcnt_r <= 3'h0;
         out_r <= 8'h00;
         ocnt_r <= 3'h0;
         ow_r <= `LANES_1;
         drive_r <= 1'b0;
         rd_req <= 1'b0;
         wr_byte <= 8'h00;
         wr_byte_vld <= 1'b0;
         array_go <= 1'b0;
         array_op <= 8'h00;
         array_addr <= 24'h000000;
         sr_wr_go <= 1'b0;
         sr_wr_data <= 16'h0000;
         sr_wr_count <= 2'h0;
         write_enable_latch <= 1'b0;
         four_line_instruction_mode <= 1'b0;
         powered_down <= 1'b0;
      end else begin
         rd_req <= 1'b0;
         wr_byte_vld <= 1'b0;
         array_go <= 1'b0;
         sr_wr_go <= 1'b0;
         // Completion clears the latch; a write enable later in this block wins.
         if (op_done) begin
            write_enable_latch <= 1'b0;
         end
         if (!sel) begin
            // Select rise runs instructions that ended on a byte boundary.
            if (cs_rise & armed_r & (bcnt_r == 3'h0)) begin
               if (st_r == ST_DONE) begin
                  case (op_r)
                     `OP_WREN: write_enable_latch <= puw_done_r;
                     `OP_WRDI: write_enable_latch <= 1'b0;
                     `OP_4LN_EN: four_line_instruction_mode <= four_line_enable_bit;
                     `OP_4LN_DIS: four_line_instruction_mode <= 1'b0;
                     `OP_RST: begin
                        four_line_instruction_mode <= 1'b0;
                        write_enable_latch <= 1'b0;
                     end
                     `OP_PD: powered_down <= 1'b1;
                     `OP_RPD: powered_down <= 1'b0;
                     default: begin
                        array_go <= 1'b1; // Erase with full address, or chip erase.
                        array_op <= op_r;
                        array_addr <= addr_r;
                     end
                  endcase
               end else if (st_r == ST_DIN) begin
                  if (op_r == `OP_WRSR) begin
                     sr_wr_go <= sr_ok & (sr_wr_count != 2'h0);
                  end else begin
                     array_go <= 1'b1;
                     array_op <= op_r;
                     array_addr <= addr_r;
                  end
               end
            end
            // Deselection abandons anything unfinished.
            st_r <= ST_CMD;
            bcnt_r <= 3'h0;
            nbyte_r <= 2'h0;
            dcnt_r <= 3'h0;
            ocnt_r <= 3'h0;
            drive_r <= 1'b0;
            w_r <= cmd_w;
         end else if (rx) begin
            sh_r <= rx_byte;
            bcnt_r <= bsum[2:0];
            case (st_r)
               ST_CMD: begin
                  if (byte_done) begin
                     op_r <= rx_byte;
                     ow_r <= cmd_w;
                     sr_wr_count <= 2'h0;
                     if (powered_down & (rx_byte != `OP_RPD)) begin
                        st_r <= ST_IGN;
                     end else begin
                        case (rx_byte)
                           `OP_WREN, `OP_WRDI, `OP_4LN_EN, `OP_4LN_DIS,
                           `OP_RST, `OP_PD, `OP_RPD: st_r <= ST_DONE;
                           `OP_RDSR1, `OP_RDSR2: st_r <= ST_DOUT;
                           `OP_WRSR: st_r <= wr_ok ? ST_DIN : ST_IGN;
                           `OP_PP, `OP_SE, `OP_BE, `OP_SECW:
                              st_r <= wr_ok ? ST_ADDR : ST_IGN;
                           `OP_CE: st_r <= wr_ok ? ST_DONE : ST_IGN;
                           `OP_FRD2: begin
                              st_r <= four_line_instruction_mode ? ST_IGN : ST_ADDR;
                              w_r <= `LANES_2;
                              ow_r <= `LANES_2;
                           end
                           `OP_FRD4: begin
                              st_r <= four_line_enable_bit ? ST_ADDR : ST_IGN;
                              w_r <= `LANES_4;
                              ow_r <= `LANES_4;
                           end
                           default: st_r <= ST_IGN;
                        endcase
                     end
                  end
               end
               ST_ADDR: begin
                  if (byte_done) begin
                     addr_r <= {addr_r[15:0], rx_byte};
                     nbyte_r <= nbyte_r + 2'h1;
                     if (nbyte_r == 2'h2) begin
                        if (is_read) begin
                           st_r <= ST_DUMMY;
                           rd_req <= 1'b1; // Prefetch the first byte.
                        end else if ((op_r == `OP_PP) | (op_r == `OP_SECW)) begin
                           st_r <= ST_DIN;
                        end else begin
                           st_r <= ST_DONE;
                        end
                     end
                  end
               end
               ST_DUMMY: begin
                  dcnt_r <= dcnt_r + 3'h1;
                  if (dcnt_r == dummy_lim - 3'h1) begin
                     st_r <= ST_DOUT;
                  end
               end
               ST_DIN: begin
                  if (byte_done) begin
                     if (op_r == `OP_WRSR) begin
                        if (sr_wr_count == 2'h0) begin
                           sr_wr_data[7:0] <= rx_byte;
                           sr_wr_count <= 2'h1;
                        end else if (sr_wr_count == 2'h1) begin
                           sr_wr_data[15:8] <= rx_byte;
                           sr_wr_count <= 2'h2;
                        end
                     end else begin
                        wr_byte <= rx_byte;
                        wr_byte_vld <= 1'b1;
                     end
                  end
               end
               ST_DONE: st_r <= ST_IGN; // Extra clocks cancel the instruction.
               ST_DOUT: st_r <= ST_DOUT; // Input lanes are don't care here.
               ST_IGN: st_r <= ST_IGN;
               default: st_r <= ST_IGN;
            endcase
         end else if (tx & (st_r == ST_DOUT)) begin
            drive_r <= 1'b1;
            if (ocnt_r == 3'h0) begin
               out_r <= is_read ? rd_data : status_byte; // Status repeats.
               ocnt_r <= 3'h0 - ow_r;
               if (is_read) begin
                  addr_r <= addr_r + 24'h000001;
                  rd_req <= 1'b1;
               end
            end else begin
               case (ow_r)
                  `LANES_1: out_r <= {out_r[6:0], 1'b0};
                  `LANES_2: out_r <= {out_r[5:0], 2'b00};
                  default: out_r <= {out_r[3:0], 4'h0};
               endcase
               ocnt_r <= ocnt_r - ow_r;
            end
         end
      end
   end
endmodule

// *** flash_front_regs.vh ***
// Purpose: Shared constants of the serial flash device-side front end.
// Assumes: Included by its bare name from the design files.
// Notes: Opcodes, lane widths, dummy counts and the power-up write delay.
`ifndef FLASH_FRONT_REGS_VH
`define FLASH_FRONT_REGS_VH

// Instruction opcodes.
`define OP_WREN    8'h06
`define OP_WRDI    8'h04
`define OP_RDSR1   8'h05
`define OP_RDSR2   8'h35
`define OP_WRSR    8'h01
`define OP_PP      8'h02
`define OP_SE      8'h20
`define OP_BE      8'hd8
`define OP_CE      8'hc7
`define OP_SECW    8'h42
`define OP_FRD2    8'hbb
`define OP_FRD4    8'heb
`define OP_4LN_EN  8'h38
`define OP_4LN_DIS 8'hff
`define OP_RST     8'h99
`define OP_PD      8'hb9
`define OP_RPD     8'hab

// Lane widths in bits per serial clock.
`define LANES_1 3'h1
`define LANES_2 3'h2
`define LANES_4 3'h4

// Status positions owned by this block.
`define SR_WEN_BIT 1
`define SR_FLE_BIT 9

// Dummy clocks after the address of the fast reads (mode byte included).
`define DUMMY_DUAL 3'h4
`define DUMMY_QUAD 3'h6

// Power-up write delay and its count of system clocks.
`define MCLK_NS 10
`define PUW_TIME_NS 10000
`define PUW_CYCLES ((`PUW_TIME_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

// *** flash_front_sva.sv ***
// Purpose: Concurrent checks on the serial flash front end ports.
// Assumes: Bound to flash_front; mclk is the only clock domain.
// Notes: A saturating counter stands in for the power-up write delay.
`timescale 1ns/100ps
module flash_front_chk (
   // Clock and reset.
   input wire mclk,
   input wire rst_b,
   // Pins and state indications watched.
   input wire spi_cs_b,
   input wire [3:0] io_oe,
   input wire paused,
   input wire four_line_instruction_mode,
   input wire four_line_enable_bit,
   input wire write_enable_latch,
   input wire powered_down,
   input wire status_protect_hi,
   input wire op_done,
   input wire array_go,
   input wire sr_wr_go
);
   // Cycles since reset release; it saturates so that it never wraps back to zero.
   reg [10:0] up_cnt_r;
   // Counts from reset release, pin reset dominates.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         up_cnt_r <= 11'h000;
      end else if (up_cnt_r != 11'h7ff) begin
         up_cnt_r <= up_cnt_r + 11'h001;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_desel_float; spi_cs_b [*6] |-> io_oe == 4'h0; endproperty
   a_desel_float: assert property (p_desel_float)
      else $error("data lines driven while deselected");
   property p_pause_float; paused |-> io_oe == 4'h0; endproperty
   a_pause_float: assert property (p_pause_float)
      else $error("data lines driven while paused");
   property p_pause_mode;
      $rose(paused) |-> !four_line_enable_bit && !four_line_instruction_mode && !spi_cs_b;
   endproperty
   a_pause_mode: assert property (p_pause_mode)
      else $error("pause taken outside single or dual operation");
   property p_4ln_entry; $rose(four_line_instruction_mode) |-> four_line_enable_bit; endproperty
   a_4ln_entry: assert property (p_4ln_entry)
      else $error("four-line mode entered without enable bit");
   property p_wen_set; $rose(write_enable_latch) |-> spi_cs_b && up_cnt_r >= 11'h3e8; endproperty
   a_wen_set: assert property (p_wen_set)
      else $error("write enable latch set too early or inside a frame");
   property p_done_clr;
      op_done && spi_cs_b && $past(spi_cs_b, 8) |=> !write_enable_latch;
   endproperty
   a_done_clr: assert property (p_done_clr)
      else $error("write enable latch kept after completion");
   property p_go_gate; $rose(array_go) |-> write_enable_latch && !powered_down; endproperty
   a_go_gate: assert property (p_go_gate)
      else $error("array operation started without write enable");
   property p_sr_gate; sr_wr_go |-> write_enable_latch && !status_protect_hi; endproperty
   a_sr_gate: assert property (p_sr_gate)
      else $error("status write started while locked");
   property p_pd_lock; powered_down && $past(powered_down) |-> !array_go && !sr_wr_go; endproperty
   a_pd_lock: assert property (p_pd_lock)
      else $error("operation started while powered down");
endmodule
bind flash_front flash_front_chk i_chk (.mclk, .rst_b, .spi_cs_b, .io_oe, .paused,
   .four_line_instruction_mode, .four_line_enable_bit, .write_enable_latch, .powered_down,
   .status_protect_hi, .op_done, .array_go, .sr_wr_go);

// *** spi_host_model.sv ***
// Purpose: Behavioural host controller that drives select, clock and data lines.
// Assumes: Tasks are called from one bench process only.
// Notes: Half period is 40 ns; data changes with the clock low, sampled at the rise.
`timescale 1ns/100ps
module spi_host_model (
   // Select and clock towards the device.
   output reg spi_clk,
   output reg spi_cs_b,
   // Host drive values and enables per data line.
   output reg [3:0] h_out,
   output reg [3:0] h_oe,
   // Resolved line levels.
   input wire [3:0] io
);
   reg m3; // Clock idles high in mode 3.
   reg wp_lvl; // Level kept on the protect pin.
   reg hold_lvl; // Level kept on the pause pin.
   // Deselected from time zero so that select is seen high first.
   initial begin
      spi_clk = 1'b0;
      spi_cs_b = 1'b1;
      h_out = 4'hc;
      h_oe = 4'hc;
      m3 = 1'b0;
      wp_lvl = 1'b1;
      hold_lvl = 1'b1;
   end
   // Selects with the clock parked at its idle level; odd offset keeps phase loose.
   task go(input md);
      begin
         #3.7;
         m3 = md;
         spi_clk = md;
         h_oe = 4'hc;
         h_out = {hold_lvl, wp_lvl, 2'b00};
         #40;
         spi_cs_b = 1'b0;
         #40;
      end
   endtask
   // Moves one byte most significant first over w lanes.
   task xb(input [7:0] b, input integer w, input drv, output [7:0] r);
      integer k;
      begin
         r = 8'h00;
         for (k = 7; k >= 0; k = k - w) begin
            spi_clk = 1'b0;
            h_oe = (w == 4) ? {4{drv}} : {2'b11, drv & (w == 2), drv};
            h_out = (w == 4) ? b[k -: 4] : {hold_lvl, wp_lvl, (w == 2) & b[k], b[k + 1 - w]};
            #40;
            spi_clk = 1'b1;
            r = (w == 4) ? {r[3:0], io} : (w == 2) ? {r[5:0], io[1:0]} : {r[6:0], io[1]};
            #40;
         end
      end
   endtask
   // Moves the pause pin with the clock low; select stays low meanwhile.
   task hold(input v);
      begin
         spi_clk = 1'b0;
         #40;
         hold_lvl = v;
         h_out[3] = v;
         h_oe[3] = 1'b1;
         #160;
      end
   endtask
   // Returns the clock to idle, then deselects.
   task fin;
      begin
         spi_clk = m3;
         #40;
         spi_cs_b = 1'b1;
         h_oe = 4'hc;
         h_out = {hold_lvl, wp_lvl, 2'b00};
         #80;
      end
   endtask
endmodule

// *** sync_bits.v ***
// Purpose: Two-flop synchroniser for a group of asynchronous inputs.
// Assumes: Each bit is independent; no word coherence is promised.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module sync_bits #(
   parameter W = 6,
   parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Asynchronous inputs and their synchronised copies.
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_r; // First stage, read only by the second stage.
         reg hold_r; // Second stage, safe for logic.
         // Each bit gets its own pair of flops.
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_r <= RST_VAL[i];
               hold_r <= RST_VAL[i];
            end else begin
               meta_r <= d[i];
               hold_r <= meta_r;
            end
         end
         assign q[i] = hold_r;
      end
   endgenerate
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench for the serial flash front end.
// Assumes: Host model drives the link at an 80 ns clock period.
// Notes: Clock mode is drawn at random for every frame opened by open; the four-line pause frame uses mode 0.
`timescale 1ns/100ps
`include "flash_front_regs.vh"
module tb;
   reg mclk, rst_b, four_line_enable_bit, status_protect_lo, status_protect_hi, op_done, tgl;
   reg [15:0] status_in, v, e, sts;
   reg [7:0] rv, d, sr_v, wb;
   reg [31:0] go_v;
   reg [23:0] a;
   integer seed, num_errors, cmp_count, go_n, sr_n, n0, k, md, rq_n;
   wire spi_clk, spi_cs_b, rd_req, wr_byte_vld, array_go, sr_wr_go, write_enable_latch;
   wire four_line_instruction_mode, powered_down, paused;
   wire [3:0] io_in, io_out, io_oe, h_out, h_oe;
   wire [7:0] rd_data, wr_byte, array_op;
   wire [23:0] rd_addr, array_addr;
   wire [15:0] sr_wr_data;
   wire [1:0] sr_wr_count;
   // Released pause and protect lines are pulled up; the others show a changing pattern.
   assign io_in = (io_oe & io_out) | (~io_oe & h_oe & h_out) | (~io_oe & ~h_oe & {2'b11, tgl, ~tgl});
   assign rd_data = rd_addr[7:0] ^ 8'h3c;
   flash_front i_dut (.mclk, .rst_b, .spi_clk, .spi_cs_b, .io_in, .io_out, .io_oe,
      .four_line_enable_bit, .status_protect_lo, .status_protect_hi, .status_in, .rd_data,
      .rd_addr, .rd_req, .wr_byte, .wr_byte_vld, .array_go, .array_op, .array_addr, .sr_wr_go,
      .sr_wr_data, .sr_wr_count, .op_done, .write_enable_latch, .four_line_instruction_mode,
      .powered_down, .paused);
   spi_host_model i_host (.spi_clk, .spi_cs_b, .h_out, .h_oe, .io(io_in));
   always #5 mclk = ~mclk;
   // Records engine requests as they leave the block.
   always @(posedge mclk) begin
      tgl <= ~tgl;
      if (array_go === 1'b1) begin
         go_n <= go_n + 1;
         go_v <= {array_op, array_addr};
      end
      if (sr_wr_go === 1'b1) begin
         sr_n <= sr_n + 1;
         sr_v <= sr_wr_data[7:0];
      end
      if (wr_byte_vld === 1'b1) wb <= wr_byte;
      if (rd_req === 1'b1) rq_n <= rq_n + 1;
   end
   function [15:0] exp_sr(input [15:0] s, input we, input fe);
      begin
         exp_sr = s;
         exp_sr[1] = we;
         exp_sr[9] = fe;
      end
   endfunction
   function [7:0] arr(input [23:0] ad);
      arr = ad[7:0] ^ 8'h3c;
   endfunction
   task chk(input [47:0] seen, input [47:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task gap;
      begin
         repeat (8) @(posedge mclk);
         #1;
      end
   endtask
   task open(input [7:0] c, input integer w);
      begin
         md = $random(seed);
         i_host.go(md[0]);
         i_host.xb(c, w, 1'b1, rv);
      end
   endtask
   task op(input [7:0] c, input integer w);
      begin
         open(c, w);
         i_host.fin;
         gap;
      end
   endtask
   task ad(input [23:0] x, input integer w);
      begin
         i_host.xb(x[23:16], w, 1'b1, rv);
         i_host.xb(x[15:8], w, 1'b1, rv);
         i_host.xb(x[7:0], w, 1'b1, rv);
      end
   endtask
   task rd2(input integer w);
      begin
         i_host.xb(8'h00, w, 1'b0, rv);
         v[15:8] = rv;
         i_host.xb(8'h00, w, 1'b0, rv);
         v[7:0] = rv;
         i_host.fin;
         gap;
      end
   endtask
   task done_pulse;
      begin
         op_done = 1'b1;
         @(posedge mclk);
         #1 op_done = 1'b0;
         gap;
      end
   endtask
   task close_out;
      begin
         $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
         if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask
   // Longest expected run is near 41 us, so 200 us means a hang.
   initial begin
      #200000;
      num_errors = num_errors + 1;
      close_out;
   end
   initial begin
      {mclk, rst_b, four_line_enable_bit, status_protect_lo, status_protect_hi, op_done} = 6'h00;
      {tgl, status_in, go_v, sr_v, wb} = 0;
      {seed, num_errors, cmp_count, go_n, sr_n, rq_n} = {32'd76, 160'd0};
      repeat (16) @(posedge mclk);
      #1 rst_b = 1'b1;
      gap;
      chk({write_enable_latch, four_line_instruction_mode, powered_down, io_oe}, 7'h00);
      op(`OP_WREN, 1);
      chk(write_enable_latch, 0);
      $display("test done: power-up lockout");
      repeat (1000) @(posedge mclk);
      #1 sts = $random(seed) | 16'h0202;
      status_in = sts;
      open(`OP_RDSR1, 1);
      i_host.hold(1'b0);
      chk({paused, io_oe}, 5'h10);
      i_host.hold(1'b1);
      chk(paused, 0);
      rd2(1);
      e = exp_sr(sts, 1'b0, 1'b0);
      chk(v, {2{e[7:0]}});
      op(`OP_WREN, 1);
      chk(write_enable_latch, 1);
      open(`OP_RDSR2, 1);
      rd2(1);
      e = exp_sr(sts, 1'b1, 1'b0);
      chk(v, {2{e[15:8]}});
      $display("test done: status read and pause");
      for (k = 0; k < 2; k = k + 1) begin
         n0 = go_n;
         a = $random(seed);
         d = $random(seed);
         open(`OP_PP, 1);
         ad(a, 1);
         i_host.xb(d, 1, 1'b1, rv);
         i_host.fin;
         gap;
         chk(go_n - n0, 1 - k);
         if (k == 0) chk({go_v, wb}, {`OP_PP, a, d});
         done_pulse;
         chk(write_enable_latch, 0);
      end
      status_protect_lo = 1'b1;
      for (k = 0; k < 2; k = k + 1) begin
         i_host.wp_lvl = k[0];
         op(`OP_WREN, 1);
         n0 = sr_n;
         d = $random(seed);
         open(`OP_WRSR, 1);
         i_host.xb(d, 1, 1'b1, rv);
         i_host.fin;
         gap;
         chk({sr_n - n0, sr_wr_count, k == 1 ? sr_v : d}, {k, 2'h1, d});
         done_pulse;
      end
      op(`OP_PD, 1);
      op(`OP_WREN, 1);
      chk({powered_down, write_enable_latch}, 2'h2);
      op(`OP_RPD, 1);
      chk(powered_down, 0);
      $display("test done: write gating");
      a = $random(seed);
      n0 = rq_n;
      open(`OP_FRD2, 1);
      ad(a, 2);
      i_host.xb(8'h00, 2, 1'b0, rv);
      rd2(2);
      chk({v, rq_n - n0}, {arr(a), arr(a + 24'h000001), 4 - md[0]});
      four_line_enable_bit = 1'b1;
      a = $random(seed);
      open(`OP_FRD4, 1);
      ad(a, 4);
      repeat (3) i_host.xb(8'h00, 4, 1'b0, rv);
      rd2(4);
      chk(v, {arr(a), arr(a + 24'h000001)});
      $display("test done: dual and quad reads");
      four_line_enable_bit = 1'b0;
      op(`OP_4LN_EN, 1);
      chk(four_line_instruction_mode, 0);
      four_line_enable_bit = 1'b1;
      op(`OP_4LN_EN, 1);
      chk(four_line_instruction_mode, 1);
      i_host.go(1'b0);
      i_host.hold(1'b0);
      chk(paused, 0);
      i_host.hold(1'b1);
      i_host.fin;
      op(`OP_4LN_DIS, 4);
      chk(four_line_instruction_mode, 0);
      op(`OP_4LN_EN, 1);
      op(`OP_RST, 4);
      chk(four_line_instruction_mode, 0);
      $display("test done: four-line mode");
      close_out;
   end
endmodule
